// ===== hw/mcb_cfg.svh
// Offsets, field positions, reset values and widths of the memory control bus block
`ifndef MCB_CFG_SVH
`define MCB_CFG_SVH
`define MCB_DATA_W 32
`define MCB_PER_W 16
`define MCB_ADDR_W 8
`define MCB_REG_CTRL 8'h00
`define MCB_REG_STATUS 8'h04
`define MCB_REG_ERRS 8'h08
`define MCB_REG_ADDR 8'h0C
`define MCB_REG_REF 8'h10
`define MCB_CTRL_ACCEPT 0
`define MCB_CTRL_DMA 1
`define MCB_CTRL_RESET 2'h3
`define MCB_ERR_SIZE 0
`define MCB_ERR_FUNC 1
`define MCB_ERR_MEM 2
`define MCB_ERR_W 3
`define MCB_SIZE_UNUSED 2'h2
`define MCB_SIZE_WORD 2'h1
`define MCB_PER_MASK 32'h0000FFFF
`define MCB_BASIC_CLK_NS 90
`define MCB_CLK_NS 100
`define MCB_RESP_OKAY 2'h0
`define MCB_RESP_SLVERR 2'h2
`endif

// ===== hw/mcb_pkg.sv
// Types of the memory control bus block
`include "mcb_cfg.svh"
package mcb_pkg;
  typedef enum logic [7:0] {
    MCB_IDLE = 8'h01, MCB_FETCH = 8'h02, MCB_HOLD = 8'h04, MCB_DRIVE = 8'h08,
    MCB_WDATA = 8'h10, MCB_STORE = 8'h20, MCB_PREF = 8'h40, MCB_DMA = 8'h80
  } mcb_state_e;
  typedef enum logic [2:0] {
    MCB_K_MRD = 3'h0, MCB_K_MWR = 3'h1, MCB_K_PRD = 3'h2, MCB_K_PWR = 3'h3,
    MCB_K_PREF = 3'h4, MCB_K_BAD = 3'h7
  } mcb_kind_e;
  typedef struct packed {
    logic mem_req;
    logic data_req;
    logic transfer_done;
    logic [1:0] access_privilege;
    logic [1:0] xfer_size;
    logic legacy_isa_flag;
    logic [5:0] reference_function;
  } mcb_dap_in_s;
  typedef struct packed {
    logic grant_n;
    logic occupied;
    logic gate_dir;
    logic prefetch_deliver;
    logic error_summary_n;
  } mcb_dap_out_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic [1:0] priv;
  } mcb_mem_req_s;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mcb_mem_rsp_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } mcb_per_req_s;
  typedef struct packed {
    logic valid;
    logic to_mem;
    logic [31:0] addr;
  } mcb_dma_req_s;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } mcb_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcb_axi_rsp_s;
  typedef struct packed {
    mcb_state_e state;
    mcb_kind_e kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
    logic [1:0] priv;
    logic legacy;
    logic grant;
    logic dreq_seen;
    logic mem_req;
    logic per_req;
    logic to_mem;
    logic [1:0] dphase;
    logic dma_done;
    logic [1:0] ctrl;
    logic [2:0] errs;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcb_st_s;
endpackage : mcb_pkg

// ===== hw/mcb_rotator.sv
// Byte rotator that realigns peripheral data on the shared lines
`timescale 1ns/1ps
module mcb_rotator #(
  parameter int W = 32
) (
  input wire logic [W-1:0] i_data,
  input wire logic [1:0] i_offset,
  input wire logic i_left,
  output logic [W-1:0] o_data
);
  logic [2*W-1:0] dbl;
  logic [1:0] right_by;
  logic [2*W-1:0] shifted;

  // A left rotation by k bytes is a right rotation by the complement
  assign dbl = {i_data, i_data};
  assign right_by = i_left ? 2'(2'h0 - i_offset) : i_offset;
  assign shifted = dbl >> {right_by, 3'h0};
  assign o_data = shifted[W-1:0];
endmodule : mcb_rotator

// ===== hw/mcb_ctrl.sv
// Memory control bus controller: reference sequencing, prefetch, peripheral routing, DMA
`timescale 1ns/1ps
`include "mcb_cfg.svh"
module mcb_ctrl
  import mcb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire mcb_dap_in_s i_dap,
  output mcb_dap_out_s o_dap,
  input wire logic [31:0] i_bus,
  output logic [31:0] o_bus,
  output logic [31:0] o_bus_oe,
  output logic o_xcvr_drive,
  output logic o_xcvr_latch,
  output mcb_per_req_s o_per,
  input wire logic i_per_ack,
  output mcb_mem_req_s o_mem,
  input wire mcb_mem_rsp_s i_mem,
  input wire mcb_dma_req_s i_dma,
  output logic o_dma_done,
  input wire mcb_axi_req_s i_axi,
  output mcb_axi_rsp_s o_axi
);
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic mcb_kind_e ref_kind(input logic [5:0] f);
    case (f[2:0])
      3'h0: ref_kind = MCB_K_MRD;
      3'h1: ref_kind = MCB_K_MWR;
      3'h2: ref_kind = MCB_K_PRD;
      3'h3: ref_kind = MCB_K_PWR;
      3'h4: ref_kind = MCB_K_PREF;
      default: ref_kind = MCB_K_BAD;
    endcase
  endfunction : ref_kind
  function automatic logic kind_reads(input mcb_kind_e k);
    kind_reads = (k != MCB_K_MWR) && (k != MCB_K_PWR);
  endfunction : kind_reads
  mcb_st_s q;
  mcb_st_s d;
  logic [31:0] rot_in;
  logic [31:0] rot_out;
  logic rot_left;
  logic [2:0] err_set;
  logic [2:0] err_clr;
  logic [31:0] rd_val;
  logic rd_hit;
  mcb_kind_e nk;
  // Inbound peripheral data is rotated up, outbound data rotated down to the low half
  assign rot_left = (q.state == MCB_FETCH) || (q.state == MCB_DMA);
  assign rot_in = rot_left ? (i_bus & `MCB_PER_MASK) : i_bus;
  mcb_rotator #(.W(`MCB_DATA_W)) u_rot (
    .i_data(rot_in),
    .i_offset(q.addr[1:0]),
    .i_left(rot_left),
    .o_data(rot_out)
  );
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    err_set = 3'h0;
    err_clr = 3'h0;
    rd_val = 32'h0;
    rd_hit = 1'b0;
    nk = ref_kind(i_dap.reference_function);
    d.grant = 1'b0;
    d.dma_done = 1'b0;
    case (q.state)
      MCB_IDLE: begin
        d.dreq_seen = 1'b0;
        if (i_dap.mem_req && q.ctrl[`MCB_CTRL_ACCEPT]) begin
          d.grant = 1'b1;
          d.addr = i_bus;
          d.kind = nk;
          d.size = i_dap.xfer_size;
          d.priv = i_dap.access_privilege;
          d.legacy = i_dap.legacy_isa_flag;
          err_set[`MCB_ERR_SIZE] = (i_dap.xfer_size == `MCB_SIZE_UNUSED);
          err_set[`MCB_ERR_FUNC] = (nk == MCB_K_BAD);
          d.data = 32'h0;
          if (nk == MCB_K_MWR || nk == MCB_K_PWR) begin
            d.state = MCB_WDATA;
          end else begin
            d.state = MCB_FETCH;
            d.mem_req = (nk == MCB_K_MRD) || (nk == MCB_K_PREF);
            d.per_req = (nk == MCB_K_PRD);
          end
        end else if (i_dma.valid && q.ctrl[`MCB_CTRL_DMA] && !q.dma_done) begin
          d.state = MCB_DMA;
          d.addr = i_dma.addr;
          d.to_mem = i_dma.to_mem;
          d.size = `MCB_SIZE_WORD;
          d.dphase = 2'h0;
        end
      end
      MCB_FETCH: begin
        d.dreq_seen = q.dreq_seen | i_dap.data_req;
        if (q.kind == MCB_K_BAD) begin
          d.state = MCB_HOLD;
        end else if (q.mem_req && i_mem.ack) begin
          d.mem_req = 1'b0;
          d.data = i_mem.rdata;
          err_set[`MCB_ERR_MEM] = i_mem.err;
          d.state = (q.kind == MCB_K_PREF) ? MCB_PREF : MCB_HOLD;
        end else if (q.per_req && i_per_ack) begin
          d.per_req = 1'b0;
          d.data = rot_out;
          d.state = MCB_HOLD;
        end
      end
      MCB_HOLD: d.state = (i_dap.data_req || q.dreq_seen) ? MCB_DRIVE : MCB_HOLD;
      MCB_DRIVE: d.state = i_dap.transfer_done ? MCB_IDLE : MCB_DRIVE;
      MCB_PREF: d.state = MCB_IDLE;
      MCB_WDATA: begin
        d.dreq_seen = q.dreq_seen | i_dap.data_req;
        if ((q.dreq_seen || i_dap.data_req) && i_dap.transfer_done) begin
          d.data = (q.kind == MCB_K_PWR) ? rot_out : i_bus;
          d.state = MCB_STORE;
          d.mem_req = (q.kind == MCB_K_MWR);
          d.per_req = (q.kind == MCB_K_PWR);
        end
      end
      MCB_STORE: begin
        if (q.mem_req && i_mem.ack) begin
          d.mem_req = 1'b0;
          err_set[`MCB_ERR_MEM] = i_mem.err;
          d.state = MCB_IDLE;
        end else if (q.per_req && i_per_ack) begin
          d.per_req = 1'b0;
          d.state = MCB_IDLE;
        end
      end
      MCB_DMA: begin
        case (q.dphase)
          2'h0: begin
            if (q.to_mem) begin
              d.data = rot_out;
            end
            d.mem_req = 1'b1;
            d.dphase = 2'h1;
          end
          2'h1: begin
            if (i_mem.ack) begin
              d.mem_req = 1'b0;
              err_set[`MCB_ERR_MEM] = i_mem.err;
              if (q.to_mem) begin
                d.dma_done = 1'b1;
                d.state = MCB_IDLE;
              end else begin
                d.data = {16'h0, q.addr[1] ? i_mem.rdata[31:16] : i_mem.rdata[15:0]};
                d.dphase = 2'h2;
              end
            end
          end
          default: begin
            d.dma_done = 1'b1;
            d.state = MCB_IDLE;
          end
        endcase
      end
      default: begin
        d.state = MCB_IDLE;
        d.mem_req = 1'b0;
        d.per_req = 1'b0;
      end
    endcase

    // Register slave: address and data may arrive in either order
    if (i_axi.awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = i_axi.wdata;
      d.wstrb0 = i_axi.wstrb[0];
    end
    if (q.bvalid && i_axi.bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (q.aw_addr == `MCB_REG_CTRL || q.aw_addr == `MCB_REG_ERRS) ?
                `MCB_RESP_OKAY : `MCB_RESP_SLVERR;
      if (q.aw_addr == `MCB_REG_CTRL && q.wstrb0) begin
        d.ctrl = q.wdata[1:0];
      end
      if (q.aw_addr == `MCB_REG_ERRS && q.wstrb0) begin
        err_clr = q.wdata[`MCB_ERR_W-1:0];
      end
    end
    if (q.rvalid && i_axi.rready) begin
      d.rvalid = 1'b0;
    end
    if (i_axi.arvalid && !q.rvalid) begin
      rd_hit = 1'b1;
      case (i_axi.araddr)
        `MCB_REG_CTRL: rd_val = {30'h0, q.ctrl};
        `MCB_REG_STATUS: rd_val = {16'h0, q.state, 6'h0, o_dap.gate_dir, o_dap.occupied};
        `MCB_REG_ERRS: rd_val = {29'h0, q.errs};
        `MCB_REG_ADDR: rd_val = q.addr;
        `MCB_REG_REF: rd_val = {24'h0, q.legacy, q.priv, q.size, q.kind};
        default: rd_hit = 1'b0;
      endcase
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_hit ? `MCB_RESP_OKAY : `MCB_RESP_SLVERR;
    end
    // A new error in the clearing cycle survives the clear
    d.errs = (q.errs & ~err_clr) | err_set;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
      q.state <= MCB_IDLE;
      q.kind <= MCB_K_MRD;
      q.ctrl <= `MCB_CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic busy;
  logic per_out;

  assign busy = (q.state != MCB_IDLE) && (q.state != MCB_DMA);
  // Peripheral writes and DMA output to the transceivers never use the upper half of the shared lines
  assign per_out = (q.state == MCB_STORE && q.kind == MCB_K_PWR) ||
                   (q.state == MCB_DMA && q.dphase == 2'h2);
  assign o_dap.grant_n = !q.grant;
  assign o_dap.occupied = busy;
  assign o_dap.gate_dir = !(busy && kind_reads(q.kind));
  assign o_dap.prefetch_deliver = (q.state == MCB_PREF);
  assign o_dap.error_summary_n = !(|q.errs);
  assign o_bus = q.data;
  assign o_bus_oe = (q.state == MCB_DRIVE || q.state == MCB_PREF) ? 32'hFFFFFFFF :
                    (per_out ? `MCB_PER_MASK : 32'h0);
  assign o_xcvr_drive = (q.state == MCB_FETCH && q.kind == MCB_K_PRD) ||
                        (q.state == MCB_DMA && q.dphase == 2'h0 && q.to_mem);
  assign o_xcvr_latch = per_out;
  assign o_per.valid = q.per_req;
  assign o_per.write = (q.kind == MCB_K_PWR);
  assign o_per.addr = q.addr;
  assign o_mem.valid = q.mem_req;
  assign o_mem.write = (q.state == MCB_STORE) || (q.state == MCB_DMA && q.to_mem);
  assign o_mem.addr = q.addr;
  assign o_mem.wdata = q.data;
  assign o_mem.size = q.size;
  assign o_mem.priv = q.priv;
  assign o_dma_done = q.dma_done;
  assign o_axi.awready = !q.aw_got;
  assign o_axi.wready = !q.w_got;
  assign o_axi.bvalid = q.bvalid;
  assign o_axi.bresp = q.bresp;
  assign o_axi.arready = !q.rvalid;
  assign o_axi.rvalid = q.rvalid;
  assign o_axi.rdata = q.rdata;
  assign o_axi.rresp = q.rresp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_request;
    !o_dap.grant_n;
  endsequence
  sequence s_after_request;
    o_dap.grant_n && (q.state != MCB_IDLE);
  endsequence
  a_ref_two_phase: assert property (s_request |=> s_after_request)
    else $error("reference finished in its request cycle");
  a_grant_cause: assert property (!o_dap.grant_n |-> $past(i_dap.mem_req) &&
      ($past(q.state) == MCB_IDLE))
    else $error("grant without a request from idle");
  a_busy_hold: assert property (s_request |=> o_dap.occupied)
    else $error("occupied not raised after grant");
  a_prefetch_drive: assert property (o_dap.prefetch_deliver |-> (o_bus_oe == 32'hFFFFFFFF)
      ##1 !o_dap.prefetch_deliver)
    else $error("prefetch strobe without bus drive or too long");
  a_gate_dir_reads: assert property (((q.state == MCB_DRIVE) |-> !o_dap.gate_dir) and
      (!o_dap.occupied |-> o_dap.gate_dir))
    else $error("direction line wrong");
  a_per_low16: assert property (o_xcvr_latch |-> (o_bus_oe == `MCB_PER_MASK))
    else $error("peripheral data on upper lines");
  a_mem_no_xcvr: assert property ((q.state == MCB_FETCH && q.kind == MCB_K_MRD) |->
      !o_xcvr_drive && !o_xcvr_latch)
    else $error("transceivers active in memory reference");
  a_per_read_rotate: assert property ((q.state == MCB_FETCH && q.kind == MCB_K_PRD &&
      i_per_ack) |=> (q.data == $past(rot_out)) && (q.state == MCB_HOLD))
    else $error("peripheral read data not realigned");
  a_write_forward: assert property ((q.state == MCB_STORE && q.kind == MCB_K_PWR) |->
      o_per.valid && o_per.write && o_xcvr_latch)
    else $error("peripheral write not forwarded");
  a_err_summary: assert property ((q.state == MCB_FETCH && q.mem_req && i_mem.ack &&
      i_mem.err) |=> !o_dap.error_summary_n)
    else $error("memory error not summarised");
  a_dma_path: assert property ((q.state == MCB_DMA && q.to_mem && q.dphase == 2'h0) |->
      o_xcvr_drive ##1 o_mem.valid && o_mem.write)
    else $error("dma data not routed to memory");
endmodule : mcb_ctrl

// ===== tb/mcb_dap_model.sv
// Data path side model that issues two-phase references (request, then data) on the shared lines
`timescale 1ns/1ps
module mcb_dap_model
  import mcb_pkg::*;
(
  input wire logic i_clk,
  input wire mcb_dap_out_s i_dap,
  input wire logic [31:0] i_bus,
  input wire logic [31:0] i_ctl_oe,
  output mcb_dap_in_s o_dap,
  output logic [31:0] o_bus,
  output logic o_bus_oe
);
  logic gd_seen;
  logic occ_seen;
  initial begin
    o_dap = '0;
    o_bus = '0;
    o_bus_oe = 1'b0;
  end
  // ----------------------------------------
  // One reference; ok stays low if no grant
  // ----------------------------------------
  task automatic ref_do(input logic [5:0] fn, input logic [1:0] sz, input logic [1:0] pv,
      input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    rd = '0;
    @(posedge i_clk);
    o_dap.mem_req <= 1'b1;
    o_dap.reference_function <= fn;
    o_dap.xfer_size <= sz;
    o_dap.access_privilege <= pv;
    o_dap.legacy_isa_flag <= pv[0];
    o_bus <= ad;
    o_bus_oe <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_dap.grant_n !== 1'b0 && n < 8);
    ok = (i_dap.grant_n === 1'b0);
    gd_seen = i_dap.gate_dir;
    occ_seen = i_dap.occupied;
    o_dap.mem_req <= 1'b0;
    n = 0;
    if (ok && fn[0] && fn[2:0] < 3'h4) begin
      // Write: data stays on the lines through the done cycle
      o_dap.data_req <= 1'b1;
      o_bus <= wd;
      @(posedge i_clk);
      o_dap.transfer_done <= 1'b1;
      @(posedge i_clk);
      o_dap.data_req <= 1'b0;
      o_dap.transfer_done <= 1'b0;
      o_bus_oe <= 1'b0;
    end else if (ok && fn[2:0] == 3'h4) begin
      o_bus_oe <= 1'b0;
      do begin
        @(posedge i_clk);
        n++;
      end while (i_dap.prefetch_deliver !== 1'b1 && n < 40);
      rd = i_bus;
    end else if (ok) begin
      o_bus_oe <= 1'b0;
      o_dap.data_req <= 1'b1;
      do begin
        @(posedge i_clk);
        n++;
      end while (i_ctl_oe !== 32'hFFFFFFFF && n < 40);
      rd = i_bus;
      o_dap.data_req <= 1'b0;
      o_dap.transfer_done <= 1'b1;
      @(posedge i_clk);
      o_dap.transfer_done <= 1'b0;
    end else begin
      o_bus_oe <= 1'b0;
    end
    n = 0;
    // No new request until the controller is free again
    do begin
      @(posedge i_clk);
      n++;
    end while (i_dap.occupied !== 1'b0 && n < 40);
  endtask : ref_do
endmodule : mcb_dap_model

// ===== tb/tb_mcb_ctrl.sv
// Self-checking bench for the memory control bus controller
`timescale 1ns/1ps
`include "mcb_cfg.svh"
module tb_mcb_ctrl
  import mcb_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  mcb_dap_in_s dap_i;
  mcb_dap_out_s dap_o;
  logic [31:0] bus, c_bus, c_oe, d_bus;
  logic [31:0] flt = 32'hA5A55A5A;
  logic d_oe, xdrv, xlat, dma_done, hit, busy, mem_e, in_mem;
  logic per_ack = 1'b0;
  logic mgap = 1'b0;
  mcb_per_req_s per_o;
  mcb_mem_req_s mem_o;
  mcb_mem_rsp_s mem_i = '0;
  mcb_dma_req_s dma_i;
  mcb_axi_req_s axi;
  mcb_axi_rsp_s axo;
  logic [31:0] mem_a [16];
  logic [15:0] per_d;
  logic [15:0] per_w = 16'h0;
  int lat, failures, n_compared;
  int cnt = 0;
  always #50 i_clk = ~i_clk;
  // Undriven lines show a pattern that flips every cycle
  assign bus = (c_bus & c_oe) | (~c_oe & (d_oe ? d_bus : xdrv ? {flt[31:16], per_d} : flt));
  mcb_ctrl u_mcb_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_dap(dap_i), .o_dap(dap_o),
    .i_bus(bus), .o_bus(c_bus), .o_bus_oe(c_oe), .o_xcvr_drive(xdrv), .o_xcvr_latch(xlat),
    .o_per(per_o), .i_per_ack(per_ack), .o_mem(mem_o), .i_mem(mem_i), .i_dma(dma_i),
    .o_dma_done(dma_done), .i_axi(axi), .o_axi(axo));
  mcb_dap_model u_mcb_dap_model (.i_clk(i_clk), .i_dap(dap_o), .i_bus(bus), .i_ctl_oe(c_oe),
    .o_dap(dap_i), .o_bus(d_bus), .o_bus_oe(d_oe));
  // ----------------------------------------
  // Memory and peripheral ends, one op each, answer after lat cycles
  // ----------------------------------------
  always @(posedge i_clk) begin
    busy = (mem_o.valid || per_o.valid) && !mgap && !mem_i.ack && !per_ack;
    hit = busy && cnt >= lat;
    flt <= ~flt;
    cnt <= (busy && !hit) ? cnt + 1 : 0;
    mgap <= mem_i.ack | per_ack;
    mem_i <= '{ack: hit && mem_o.valid, err: hit && mem_o.valid && mem_e,
      rdata: (hit && mem_o.valid) ? mem_a[mem_o.addr[5:2]] : flt};
    per_ack <= hit && !mem_o.valid;
    if (hit && mem_o.valid && mem_o.write) mem_a[mem_o.addr[5:2]] <= mem_o.wdata;
    if (hit && !mem_o.valid && per_o.write) per_w <= c_bus[15:0];
    if (xlat && !per_o.valid) per_w <= c_bus[15:0];
    if (in_mem && (xdrv || xlat)) fail("transceivers used in a memory reference");
    if (xlat && c_oe !== 32'h0000FFFF) fail("peripheral data off the low lines");
  end
  task automatic fail(input string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask : chk_v
  task automatic chk_f(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask : chk_f
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_clk);
    axi.awvalid <= 1'b1;
    axi.awaddr <= a;
    axi.wvalid <= 1'b1;
    axi.wdata <= d;
    axi.wstrb <= 4'hF;
    axi.bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (!aw && axo.awready === 1'b1) begin
        aw = 1'b1;
        axi.awvalid <= 1'b0;
      end
      if (!w && axo.wready === 1'b1) begin
        w = 1'b1;
        axi.wvalid <= 1'b0;
      end
    end while (axo.bvalid !== 1'b1);
    r = axo.bresp;
    axi.bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b0;
    @(posedge i_clk);
    axi.arvalid <= 1'b1;
    axi.araddr <= a;
    axi.rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (!ar && axo.arready === 1'b1) begin
        ar = 1'b1;
        axi.arvalid <= 1'b0;
      end
    end while (axo.rvalid !== 1'b1);
    d = axo.rdata;
    r = axo.rresp;
    axi.rready <= 1'b0;
  endtask : axi_rd
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [1:0] r;
    logic ok;
    int n;
    axi = '0;
    dma_i = '0;
    mem_e = 1'b0;
    in_mem = 1'b0;
    per_d = 16'h5A3C;
    lat = 0;
    failures = 0;
    n_compared = 0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk_f(dap_o.grant_n, 1'b1, "grant at reset");
    chk_f(dap_o.occupied, 1'b0, "occupied at reset");
    chk_f(dap_o.gate_dir, 1'b1, "direction at reset");
    chk_f(dap_o.error_summary_n, 1'b1, "error summary at reset");
    axi_rd(`MCB_REG_CTRL, rd, r);
    chk_v(rd, {30'h0, `MCB_CTRL_RESET}, "control reset value");
    axi_rd(8'h40, rd, r);
    chk_v({30'h0, r}, {30'h0, `MCB_RESP_SLVERR}, "unmapped response");
    end_test("registers");
    in_mem <= 1'b1;
    // Prompt and slow memory, every privilege code
    for (int p = 0; p < 4; p++) begin
      lat = 4 * p;
      u_mcb_dap_model.ref_do(6'h01, 2'h3, p[1:0], 32'h100 + 4 * p, 32'hC0DE0000 + p, rd, ok);
      chk_f(u_mcb_dap_model.gd_seen, 1'b1, "direction on write");
      u_mcb_dap_model.ref_do(6'h00, 2'h3, p[1:0], 32'h100 + 4 * p, 32'h0, rd, ok);
      chk_v(rd, 32'hC0DE0000 + p, "memory read data");
      chk_f(u_mcb_dap_model.gd_seen, 1'b0, "direction on read");
      chk_f(u_mcb_dap_model.occ_seen, 1'b1, "occupied at grant");
      axi_rd(`MCB_REG_REF, rd, r);
      chk_v({24'h0, rd[7:0]}, {24'h0, p[0], p[1:0], 5'h18}, "reference fields");
    end
    u_mcb_dap_model.ref_do(6'h04, 2'h3, 2'h3, 32'h108, 32'h0, rd, ok);
    chk_v(rd, 32'hC0DE0002, "prefetch data");
    in_mem <= 1'b0;
    end_test("memory");
    for (int o = 0; o < 4; o += 2) begin
      u_mcb_dap_model.ref_do(6'h02, 2'h1, 2'h0, 32'h1000 + o, 32'h0, rd, ok);
      chk_v({16'h0, (o == 0) ? rd[15:0] : rd[31:16]}, {16'h0, per_d}, "periph read");
      u_mcb_dap_model.ref_do(6'h03, 2'h1, 2'h0, 32'h1000 + o, 32'hBEEF1234, rd, ok);
      chk_v({16'h0, per_w}, (o == 0) ? 32'h1234 : 32'hBEEF, "periph write");
    end
    end_test("peripheral");
    u_mcb_dap_model.ref_do(6'h07, 2'h3, 2'h0, 32'h100, 32'h0, rd, ok);
    chk_v(rd, 32'h0, "bad function data");
    u_mcb_dap_model.ref_do(6'h00, `MCB_SIZE_UNUSED, 2'h0, 32'h100, 32'h0, rd, ok);
    mem_e <= 1'b1;
    u_mcb_dap_model.ref_do(6'h00, 2'h3, 2'h0, 32'h100, 32'h0, rd, ok);
    mem_e <= 1'b0;
    chk_f(dap_o.error_summary_n, 1'b0, "error summary set");
    axi_rd(`MCB_REG_ERRS, rd, r);
    chk_v(rd, 32'h7, "error bits");
    axi_wr(`MCB_REG_ERRS, 32'h7, r);
    axi_rd(`MCB_REG_ERRS, rd, r);
    chk_v(rd, 32'h0, "error bits cleared");
    chk_f(dap_o.error_summary_n, 1'b1, "error summary cleared");
    end_test("errors");
    axi_wr(`MCB_REG_CTRL, 32'h2, r);
    u_mcb_dap_model.ref_do(6'h00, 2'h3, 2'h0, 32'h100, 32'h0, rd, ok);
    chk_f(ok, 1'b0, "grant while accept off");
    axi_wr(`MCB_REG_CTRL, 32'h3, r);
    // Into memory first, then the same word back out to the transceivers
    for (int t = 1; t >= 0; t--) begin
      @(posedge i_clk);
      dma_i <= '{valid: 1'b1, to_mem: t[0], addr: 32'h20};
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (dma_done !== 1'b1 && n < 40);
      dma_i <= '0;
      chk_f(dma_done, 1'b1, "dma completion");
    end
    chk_v({16'h0, mem_a[8][15:0]}, {16'h0, per_d}, "dma data in memory");
    chk_v({16'h0, per_w}, {16'h0, per_d}, "dma data to transceivers");
    end_test("refusal and dma");
    test_done();
  end
  // Whole run is a few hundred cycles; the 5000-cycle limit leaves wide margin
  initial begin
    #500000;
    fail("watchdog ran out");
    test_done();
  end
endmodule : tb_mcb_ctrl
